// >>> core/expander_pkg.sv
// constants, states and buffer word for the i2c port expander core
package expander_pkg;
  // clock and bus line filtering
  localparam int CLK_PERIOD_NS = 8;
  localparam int SPIKE_NS = 50;
  localparam int FILT_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] FILT_MAX = 3'(FILT_CYC - 1);
  // synchroniser vector layout and reset value
  localparam int SY_RSTN = 27;
  localparam int SY_ADDR = 26;
  localparam int SY_SDA = 24;
  localparam logic [27:0] SYNC_RST = 28'hb00_0000;
  // target address: upper six bits fixed, low bit from strap
  localparam logic [5:0] ADDR_BASE = 6'h11;
  // bit counts
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_TX_LAST = 4'h7;
  // command byte fields
  localparam int AUTO_BIT = 7;
  localparam logic [1:0] BANK_IN = 2'h0;
  localparam logic [1:0] BANK_OUT = 2'h1;
  localparam logic [1:0] BANK_POL = 2'h2;
  localparam logic [1:0] IDX_LAST = 2'h2;
  localparam logic [1:0] IDX_RSVD = 2'h3;
  localparam logic [7:0] RSVD_DATA = 8'h00;
  // reset values
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [23:0] OUT_RST = 24'hff_ffff;
  localparam logic [23:0] POL_RST = 24'h00_0000;
  localparam logic [23:0] DRV_RST = 24'h00_0000;
  // receive buffer
  localparam int FIFO_DEPTH = 2;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  localparam logic [1:0] FIFO_EMPTY = 2'h0;
  // bus engine states
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WR, ST_ACK, ST_TX, ST_MACK} bus_state_e;
  // received byte with its command marker
  typedef struct packed {
    logic is_cmd;
    logic [7:0] data;
  } rx_word_s;
endpackage : expander_pkg

// >>> core/i2c_port_expander_core.sv
// two-wire target with 24-bit port, direction, polarity and change interrupt
// Notes on behaviour
// - answer address 0x22 or 0x23 by strap
// - address low bit: one read, zero write
// - sda fall with scl high starts address
// - sda rise with scl high stops, idle
// - bytes shift msb first, one per pulse
// - matching address acked low through ninth pulse
// - sda change while scl high is control
// - every written byte acked by device
// - controller nack: device releases sda
// - transmitter releases sda after eighth bit
// - power-on reset sets defaults
// - low reset pin forces defaults
// - input pin edge asserts interrupt low
// - clear on level return or port read
// - read clear at ack rising scl
// - later changes raise interrupt again
// - outputs and foreign traffic never interrupt
// - output to input switch may interrupt
// - input pins undriven, outputs follow register
// - all pins inputs after reset
// - first written byte is the command
// - auto step cycles low bits within bank
// - reads return register the command selects
// - command codes select four banks of three
module i2c_port_expander_core
  import expander_pkg::*;
(
  // clock and resets
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic reset_n_i,
  // bus lines, open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // address strap
  input wire logic addr_sel_i,
  // port pins, two-way
  input wire logic [23:0] port_pins_i,
  output logic [23:0] port_pins_o,
  output logic [23:0] port_pins_oe_o,
  // interrupt, open drain active low
  output logic irq_n_o,
  output logic irq_n_oe_o
);

  // two-stage synchroniser for every outside input except reset_i
  logic [27:0] sync1_q, sync1_d, sync2_q, sync2_d;
  always_comb
  begin
    sync1_d = {reset_n_i, addr_sel_i, scl_i, sda_i, port_pins_i};
    sync2_d = sync1_q;
  end
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // combined reset and synchronised levels
  logic rst_all;
  logic addr_s;
  logic [23:0] pins_s;
  assign rst_all = reset_i | ~sync2_q[SY_RSTN];
  assign addr_s = sync2_q[SY_ADDR];
  assign pins_s = sync2_q[23:0];

  // spike filter: index 0 sda, index 1 scl
  logic [1:0] filt_q, filt_d, prev_q, prev_d;
  logic [1:0][2:0] fcnt_q, fcnt_d;
  always_comb
  begin
    prev_d = filt_q;
    filt_d = filt_q;
    fcnt_d = fcnt_q;
    for (int i = 0; i < 2; i++)
    begin
      if (sync2_q[SY_SDA + i] == filt_q[i])
        fcnt_d[i] = 3'h0;
      else if (fcnt_q[i] == FILT_MAX)
      begin
        filt_d[i] = sync2_q[SY_SDA + i];
        fcnt_d[i] = 3'h0;
      end
      else
        fcnt_d[i] = 3'(fcnt_q[i] + 3'h1);
    end
  end
  always_ff @(posedge clock_i)
  begin
    if (rst_all)
    begin
      filt_q <= 2'h3;
      prev_q <= 2'h3;
      fcnt_q <= '0;
    end
    else
    begin
      filt_q <= filt_d;
      prev_q <= prev_d;
      fcnt_q <= fcnt_d;
    end
  end

  // bus events from filtered lines
  logic scl_rise, scl_fall, start_w, stop_w;
  assign scl_rise = filt_q[1] & ~prev_q[1];
  assign scl_fall = ~filt_q[1] & prev_q[1];
  assign start_w = filt_q[1] & prev_q[1] & prev_q[0] & ~filt_q[0];
  assign stop_w = filt_q[1] & prev_q[1] & ~prev_q[0] & filt_q[0];

  // engine and register state
  bus_state_e state_q, state_d;
  logic [3:0] bitcnt_q, bitcnt_d;
  logic [7:0] shreg_q, shreg_d;
  logic rw_q, rw_d, first_q, first_d, acked_q, acked_d, sda_oe_q, sda_oe_d;
  logic [7:0] cmd_q, cmd_d, rd_data_w;
  logic [23:0] out_q, out_d, pol_q, pol_d, drv_q, drv_d, snap_q, snap_d;
  logic snap_ok_q, snap_ok_d, irq_q, irq_d;
  logic [1:0] settle_q, settle_d; // synchroniser fill count, snapshot waits for real pin levels
  logic [23:0] sel_mask_w, wval_w, in_val_w, bank_w, mism_w;

  // two-entry receive buffer between engine and registers
  rx_word_s [FIFO_DEPTH-1:0] fifo_q, fifo_d;
  rx_word_s head_w, push_data_w;
  logic wptr_q, wptr_d, rptr_q, rptr_d;
  logic [1:0] fcount_q, fcount_d;
  logic push_w, pop_w, in_ready_w, out_valid_w, drain_ready_w;
  assign in_ready_w = fcount_q != FIFO_FULL;
  assign out_valid_w = fcount_q != FIFO_EMPTY;
  assign head_w = fifo_q[rptr_q];
  assign push_w = state_q == ST_WR && scl_fall && bitcnt_q == BIT_LAST && in_ready_w;
  assign push_data_w = '{is_cmd: first_q, data: shreg_q};
  // drain stalls until the acknowledge of the byte completes
  assign drain_ready_w = scl_fall && state_q == ST_ACK && !rw_q;
  assign pop_w = out_valid_w & drain_ready_w;
  always_comb
  begin
    fifo_d = fifo_q;
    if (push_w)
      fifo_d[wptr_q] = push_data_w;
    wptr_d = wptr_q ^ push_w;
    rptr_d = rptr_q ^ pop_w;
    fcount_d = 2'(fcount_q + {1'b0, push_w} - {1'b0, pop_w});
  end
  always_ff @(posedge clock_i)
  begin
    if (rst_all)
    begin
      fifo_q <= '0;
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
      fcount_q <= FIFO_EMPTY;
    end
    else
    begin
      fifo_q <= fifo_d;
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      fcount_q <= fcount_d;
    end
  end

  // read data selected by the stored command
  always_comb
  begin
    in_val_w = pins_s ^ pol_q;
    case (cmd_q[3:2])
      BANK_IN: bank_w = in_val_w;
      BANK_OUT: bank_w = out_q;
      BANK_POL: bank_w = pol_q;
      default: bank_w = ~drv_q;
    endcase
    rd_data_w = RSVD_DATA;
    if (cmd_q[1:0] != IDX_RSVD)
      rd_data_w = bank_w[{cmd_q[1:0], 3'h0} +: 8];
  end

  // bus engine next state
  always_comb
  begin
    state_d = state_q;
    bitcnt_d = bitcnt_q;
    shreg_d = shreg_q;
    rw_d = rw_q;
    first_d = first_q;
    acked_d = acked_q;
    sda_oe_d = sda_oe_q;
    if (start_w)
    begin
      state_d = ST_ADDR;
      bitcnt_d = 4'h0;
      sda_oe_d = 1'b0;
    end
    else if (stop_w)
    begin
      state_d = ST_IDLE;
      sda_oe_d = 1'b0;
    end
    else
      case (state_q)
        // receive address or data byte
        ST_ADDR, ST_WR:
          if (scl_rise)
          begin
            shreg_d = {shreg_q[6:0], filt_q[0]};
            bitcnt_d = 4'(bitcnt_q + 4'h1);
          end
          else if (scl_fall && bitcnt_q == BIT_LAST)
          begin
            bitcnt_d = 4'h0;
            if (state_q == ST_WR && in_ready_w)
            begin
              first_d = 1'b0;
              sda_oe_d = 1'b1;
              state_d = ST_ACK;
            end
            else if (state_q == ST_ADDR && shreg_q[7:1] == {ADDR_BASE, addr_s})
            begin
              rw_d = shreg_q[0];
              first_d = ~shreg_q[0];
              sda_oe_d = 1'b1;
              state_d = ST_ACK;
            end
            else
              state_d = ST_IDLE;
          end
        // device drives ack, then hands over
        ST_ACK:
          if (scl_fall)
          begin
            sda_oe_d = 1'b0;
            state_d = ST_WR;
            if (rw_q)
            begin
              shreg_d = rd_data_w;
              sda_oe_d = ~rd_data_w[7];
              state_d = ST_TX;
            end
          end
        // transmit byte
        ST_TX:
          if (scl_fall)
          begin
            if (bitcnt_q == BIT_TX_LAST)
            begin
              sda_oe_d = 1'b0;
              bitcnt_d = 4'h0;
              state_d = ST_MACK;
            end
            else
            begin
              shreg_d = {shreg_q[6:0], 1'b0};
              sda_oe_d = ~shreg_q[6];
              bitcnt_d = 4'(bitcnt_q + 4'h1);
            end
          end
        // controller ack of a read byte
        ST_MACK:
          if (scl_rise)
            acked_d = ~filt_q[0];
          else if (scl_fall)
          begin
            state_d = ST_IDLE;
            if (acked_q)
            begin
              shreg_d = rd_data_w;
              sda_oe_d = ~rd_data_w[7];
              state_d = ST_TX;
            end
          end
        default: state_d = state_q;
      endcase
  end
  always_ff @(posedge clock_i)
  begin
    if (rst_all)
    begin
      state_q <= ST_IDLE;
      bitcnt_q <= 4'h0;
      shreg_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      acked_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      bitcnt_q <= bitcnt_d;
      shreg_q <= shreg_d;
      rw_q <= rw_d;
      first_q <= first_d;
      acked_q <= acked_d;
      sda_oe_q <= sda_oe_d;
    end
  end

  // pointer advance within a bank of three
  function automatic logic [7:0] step_cmd(input logic [7:0] c);
    logic [1:0] nxt;
    nxt = (c[1:0] >= IDX_LAST) ? 2'h0 : 2'(c[1:0] + 2'h1);
    step_cmd = c[AUTO_BIT] ? {c[7:2], nxt} : c;
  endfunction : step_cmd

  // register file, snapshot and interrupt next state
  assign sel_mask_w = 24'(24'hff << {cmd_q[1:0], 3'h0});
  assign wval_w = {3{head_w.data}};
  assign mism_w = (pins_s ^ snap_q) & ~drv_q;
  always_comb
  begin
    cmd_d = cmd_q;
    out_d = out_q;
    pol_d = pol_q;
    drv_d = drv_q;
    snap_d = snap_q;
    // first two cycles after reset the synchroniser still holds its reset value
    settle_d = {settle_q[0], 1'b1};
    snap_ok_d = settle_q[1];
    if (!snap_ok_q)
      snap_d = pins_s;
    if (pop_w && head_w.is_cmd)
      cmd_d = head_w.data;
    else if (pop_w)
    begin
      case (cmd_q[3:2])
        BANK_OUT: out_d = (out_q & ~sel_mask_w) | (wval_w & sel_mask_w);
        BANK_POL: pol_d = (pol_q & ~sel_mask_w) | (wval_w & sel_mask_w);
        BANK_IN: cmd_d = cmd_q;
        default: drv_d = (drv_q & ~sel_mask_w) | (~wval_w & sel_mask_w);
      endcase
      cmd_d = step_cmd(cmd_q);
    end
    else if (state_q == ST_MACK && scl_rise)
    begin
      if (cmd_q[3:2] == BANK_IN)
        snap_d = (snap_q & ~sel_mask_w) | (pins_s & sel_mask_w);
      cmd_d = step_cmd(cmd_q);
    end
    irq_d = snap_ok_q & (|mism_w);
  end
  always_ff @(posedge clock_i)
  begin
    if (rst_all)
    begin
      cmd_q <= CMD_RST;
      out_q <= OUT_RST;
      pol_q <= POL_RST;
      drv_q <= DRV_RST;
      snap_q <= '0;
      snap_ok_q <= 1'b0;
      settle_q <= 2'h0;
      irq_q <= 1'b0;
    end
    else
    begin
      cmd_q <= cmd_d;
      out_q <= out_d;
      pol_q <= pol_d;
      drv_q <= drv_d;
      snap_q <= snap_d;
      snap_ok_q <= snap_ok_d;
      settle_q <= settle_d;
      irq_q <= irq_d;
    end
  end

  // pin drivers straight from registers
  assign port_pins_o = out_q;
  assign port_pins_oe_o = drv_q;
  assign sda_oe_o = sda_oe_q;
  assign irq_n_oe_o = irq_q;
  assign sda_o = 1'b0;
  assign irq_n_o = 1'b0;

  // checks on bus sequencing and interrupt
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_all);
  sequence s_addr_hit;
    state_q == ST_ADDR && scl_fall && bitcnt_q == BIT_LAST && shreg_q[7:1] == {ADDR_BASE, addr_s};
  endsequence
  sequence s_read_nack;
    state_q == ST_MACK && scl_rise && filt_q[0] ##1 !scl_rise [*1];
  endsequence
  chk_addr_ack: assert property (s_addr_hit |=> sda_oe_q && state_q == ST_ACK)
    else $error("matching address not acknowledged");
  chk_ack_low: assert property (state_q == ST_ACK |-> sda_oe_q)
    else $error("sda released during acknowledge");
  chk_data_ack: assert property (push_w |=> sda_oe_q && state_q == ST_ACK)
    else $error("received byte not acknowledged");
  chk_tx_release: assert property (state_q == ST_MACK |-> !sda_oe_q)
    else $error("sda driven in controller ack slot");
  chk_nack_release: assert property (s_read_nack |-> !acked_q)
    else $error("nack taken as ack");
  chk_start_addr: assert property (start_w |=> state_q == ST_ADDR && bitcnt_q == 4'h0)
    else $error("start did not begin address");
  chk_stop_idle: assert property (stop_w |=> state_q == ST_IDLE && !sda_oe_q)
    else $error("stop did not return to idle");
  chk_reset_dir: assert property ($fell(rst_all) |-> port_pins_oe_o == 24'h0 && !irq_n_oe_o)
    else $error("pins not inputs after reset");
  chk_irq_raise: assert property (snap_ok_q && mism_w != 24'h0 |=> irq_n_oe_o)
    else $error("input change did not raise interrupt");
  chk_irq_drop: assert property (snap_ok_q && mism_w == 24'h0 |=> !irq_n_oe_o)
    else $error("interrupt held without change");
endmodule : i2c_port_expander_core

// >>> tb/i2c_ctl_model.sv
// bus controller model: drives the clock line and pulls the data line open-drain
module i2c_ctl_model
(
  // bench clock and resolved data line
  input wire logic clock_i,
  input wire logic sda_i,
  // clock line level, data pull-down (high pulls low)
  output logic scl_o = 1'b1,
  output logic sda_low_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // cycles per clock phase; kept above the device's spike filter span
  localparam int PH = 14;

  // wait n edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick

  // one bit: data set while the clock is low, sampled late in the high phase
  task automatic bit_io(input logic tx, output logic rx);
    sda_low_o = ~tx;
    tick(2);
    scl_o = 1'b1;
    tick(PH);
    rx = sda_i;
    scl_o = 1'b0;
    tick(PH);
  endtask : bit_io

  // start or repeated start: data falls while the clock is high
  task automatic start();
    sda_low_o = 1'b0;
    tick(PH);
    scl_o = 1'b1;
    tick(PH);
    sda_low_o = 1'b1;
    tick(PH);
    scl_o = 1'b0;
    tick(PH);
  endtask : start

  // stop: data rises while the clock is high
  task automatic stop();
    sda_low_o = 1'b1;
    tick(2);
    scl_o = 1'b1;
    tick(PH);
    sda_low_o = 1'b0;
    tick(PH);
  endtask : stop

  // byte out, msb first, line released for the acknowledge
  task automatic byte_wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : byte_wr

  // byte in; acknowledge all but the last
  task automatic byte_rd(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(~more, r);
  endtask : byte_rd
endmodule : i2c_ctl_model

// >>> tb/tb_top.sv
// self-checking bench for the i2c port expander core
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic reset_n = 1'b1;
  logic addr_sel = 1'b0;
  logic [23:0] ext = 24'h5a_c396;
  // controller and device outputs
  logic scl, sda_low, sda_oe, sda_o, irq_n, irq_oe;
  logic [23:0] pin_o, pin_oe;
  // open-drain data line with pull-up; pins resolved from drive and outside level
  wire logic sda = ~(sda_low | (sda_oe & ~sda_o));
  wire logic [23:0] pins = (pin_oe & pin_o) | (~pin_oe & ext);
  // open-drain interrupt line with pull-up
  wire logic irq_line = ~(irq_oe & ~irq_n);
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  logic ack;
  logic [7:0] b;

  always #4 clock = ~clock;

  i2c_ctl_model ctl (.clock_i(clock), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  i2c_port_expander_core uut (.clock_i(clock), .reset_i(reset), .reset_n_i(reset_n), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_sel_i(addr_sel), .port_pins_i(pins),
    .port_pins_o(pin_o), .port_pins_oe_o(pin_oe), .irq_n_o(irq_n), .irq_n_oe_o(irq_oe));

  // hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  // compare and count
  task automatic check(input string nm, input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // start plus address byte, acknowledge compared
  task automatic addr(input logic [7:0] a, input logic exp);
    ctl.start();
    ctl.byte_wr(a, ack);
    check("addr ack", 24'(ack), 24'(exp));
  endtask : addr

  // written bytes must each be acknowledged
  task automatic wr(input logic [7:0] d[$]);
    foreach (d[i])
    begin
      ctl.byte_wr(d[i], ack);
      check("data ack", 24'(ack), 24'h1);
    end
  endtask : wr

  // write frame: command then data
  task automatic wreg(input logic [7:0] d[$]);
    addr(8'h44, 1'b1);
    wr(d);
    ctl.stop();
  endtask : wreg

  // read frame: command, repeated start, bytes, last refused
  task automatic rdreg(input logic [7:0] cmd, input logic [7:0] e[$]);
    addr(8'h44, 1'b1);
    wr('{cmd});
    addr(8'h45, 1'b1);
    foreach (e[i])
    begin
      ctl.byte_rd(i < e.size() - 1, b);
      check("read byte", 24'(b), 24'(e[i]));
    end
    ctl.stop();
  endtask : rdreg

  // interrupt line after the pin path has settled
  task automatic irq_is(input logic exp);
    ctl.tick(20);
    check("irq", 24'(irq_oe), 24'(exp));
    check("irq line", 24'(irq_line), 24'(!exp));
  endtask : irq_is

  // closing verdict
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // test sequence
  initial
  begin
    repeat (16) @(posedge clock);
    #1;
    reset = 1'b0;
    ctl.tick(12);
    check("pin oe", pin_oe, 24'h0);
    check("pin out", pin_o, 24'hff_ffff);
    check("irq", 24'(irq_oe), 24'h0);
    rdreg(8'h8c, '{8'hff, 8'hff, 8'hff, 8'hff});
    $display("test defaults done");
    addr(8'h46, 1'b0);
    ctl.stop();
    addr(8'h48, 1'b0);
    ctl.stop();
    addr_sel = 1'b1;
    addr(8'h44, 1'b0);
    ctl.stop();
    addr(8'h46, 1'b1);
    ctl.stop();
    addr_sel = 1'b0;
    $display("test address done");
    wreg('{8'h86, 8'ha5, 8'h3c, 8'h81});
    wreg('{8'h8c, 8'h00, 8'hff, 8'h0f});
    check("pin oe", pin_oe, 24'hf0_00ff);
    check("pin out", pin_o, 24'ha5_813c);
    rdreg(8'h84, '{8'h3c, 8'h81, 8'ha5, 8'h3c});
    check("sda release", 24'(sda_oe), 24'h0);
    rdreg(8'h07, '{8'h00});
    wreg('{8'h09, 8'h0f});
    rdreg(8'h09, '{8'h0f});
    rdreg(8'h01, '{8'hcc, 8'hcc});
    $display("test registers done");
    ext[9] = ~ext[9];
    irq_is(1'b1);
    ext[9] = ~ext[9];
    irq_is(1'b0);
    ext[10] = ~ext[10];
    irq_is(1'b1);
    addr(8'h60, 1'b0);
    ctl.stop();
    irq_is(1'b1);
    rdreg(8'h01, '{8'hc8});
    irq_is(1'b0);
    ext[10] = ~ext[10];
    irq_is(1'b1);
    rdreg(8'h01, '{8'hcc});
    wreg('{8'h04, 8'h3d});
    irq_is(1'b0);
    $display("test interrupt done");
    addr(8'h44, 1'b1);
    reset_n = 1'b0;
    ctl.tick(5);
    check("pin oe", pin_oe, 24'h0);
    check("pin out", pin_o, 24'hff_ffff);
    check("sda", 24'(sda_oe), 24'h0);
    reset_n = 1'b1;
    ctl.stop();
    ctl.tick(12);
    rdreg(8'h0c, '{8'hff});
    $display("test reset pin done");
    report_and_stop();
  end
endmodule : tb_top
